// [acs_pkg.sv]
// Purpose: shared constants for the single extra conversion control block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   printed offsets are register indices; byte address is four times the index
package acs_pkg;
  // register indices as printed, and the word-aligned byte addresses derived from them
  localparam logic [15:0] IDX_CTRL  = 16'h00b6;
  localparam logic [15:0] IDX_TEST  = 16'h624b;
  localparam logic [15:0] IDX_STAT  = 16'h00b7;
  localparam logic [31:0] ADDR_CTRL = {14'h0000, IDX_CTRL, 2'b00};
  localparam logic [31:0] ADDR_TEST = {14'h0000, IDX_TEST, 2'b00};
  localparam logic [31:0] ADDR_STAT = {14'h0000, IDX_STAT, 2'b00};

  // control register fields
  localparam int REF_LSB  = 6;
  localparam int DIV_LSB  = 4;
  localparam int CH_LSB   = 0;
  // test register field
  localparam int ROUTE_BIT = 0;
  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;

  // decimation base rate for code 00, doubled by each code step
  localparam logic [9:0] DECIM_BASE = 10'h040;

  // effective resolution per decimation code
  localparam logic [3:0] ENOB_64  = 4'h7;
  localparam logic [3:0] ENOB_128 = 4'h9;
  localparam logic [3:0] ENOB_256 = 4'ha;
  localparam logic [3:0] ENOB_512 = 4'hc;

  // special channel codes
  localparam logic [3:0] CH_GND  = 4'hc;
  localparam logic [3:0] CH_RSVD = 4'hd;
  localparam logic [3:0] CH_TEMP = 4'he;
  localparam logic [3:0] CH_VDD3 = 4'hf;

  typedef enum logic [1:0] {
    ACS_IDLE = 2'b01,
    ACS_BUSY = 2'b10
  } acs_state_t;
endpackage

// [acs_chan_decode.sv]
// Purpose: turns the channel code and routing bit into registered mux selects
// Assumes: same clock and reset as the control block
// Notes:   all selects are registered so the analog mux never sees decode glitches
`timescale 1ns/100ps
`default_nettype none
module acs_chan_decode (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic [3:0] single_channel_select,
  input  wire logic       temp_sensor_route,
  output logic      [7:0] pos_sel_ff,
  output logic      [7:0] neg_sel_ff,
  output logic            gnd_sel_ff,
  output logic            temp_sel_ff,
  output logic            vdd3_sel_ff
);
  wire logic       is_single = ~single_channel_select[3];
  wire logic       is_diff   = single_channel_select[3] & ~single_channel_select[2];
  wire logic [7:0] nxt_pos;
  wire logic [7:0] nxt_neg;

  // single inputs take one positive leg; pairs take even leg positive, odd negative
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_leg
      if (g % 2 == 0) begin : g_even
        assign nxt_pos[g] = (is_single & (single_channel_select[2:0] == 3'(g)))
                          | (is_diff & (single_channel_select[1:0] == 2'(g / 2)));
        assign nxt_neg[g] = 1'b0;
      end else begin : g_odd
        assign nxt_pos[g] = is_single & (single_channel_select[2:0] == 3'(g));
        assign nxt_neg[g] = is_diff & (single_channel_select[1:0] == 2'(g / 2));
      end
    end
  endgenerate

  // reserved code 1101 selects no leg; only the routing bit can still raise temp_sel_ff
  always_ff @(posedge clock) begin
    if (srst) begin
      pos_sel_ff  <= 8'h00;
      neg_sel_ff  <= 8'h00;
      gnd_sel_ff  <= 1'b0;
      temp_sel_ff <= 1'b0;
      vdd3_sel_ff <= 1'b0;
    end else begin
      pos_sel_ff  <= nxt_pos;
      neg_sel_ff  <= nxt_neg;
      gnd_sel_ff  <= single_channel_select == acs_pkg::CH_GND;
      temp_sel_ff <= (single_channel_select == acs_pkg::CH_TEMP) | temp_sensor_route;
      vdd3_sel_ff <= single_channel_select == acs_pkg::CH_VDD3;
    end
  end

  // reserved channel code must leave every leg open
  rsvd_open_a: assert property (@(posedge clock) disable iff (srst)
    $past(single_channel_select) == acs_pkg::CH_RSVD && !$past(temp_sensor_route)
    |-> pos_sel_ff == 8'h00 && neg_sel_ff == 8'h00 && !temp_sel_ff)
    else $error("reserved channel selected an input");
endmodule
`default_nettype wire

// [acs_ctrl.sv]
// Purpose: register block and sequencing for one extra converter conversion
// Assumes: AHB-Lite slave, zero wait states, word accesses, OKAY only
// Notes:   the core takes start pulse and settings; busy window is timed here
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module acs_ctrl #(
  parameter logic [7:0] CYC_PER_DECIM = 8'h01
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata_ff,
  output logic             hreadyout_ff,
  output logic             hresp_ff,
  output logic      [1:0]  single_reference_select_ff,
  output logic      [1:0]  single_decimation_select_ff,
  output logic      [3:0]  single_channel_select_ff,
  output logic      [3:0]  result_bits_ff,
  output logic             temp_sensor_route_ff,
  output logic             conv_start_ff,
  output logic             conv_busy_ff,
  output logic             conv_done_ff,
  output logic      [7:0]  pos_sel_ff,
  output logic      [7:0]  neg_sel_ff,
  output logic             gnd_sel_ff,
  output logic             temp_sel_ff,
  output logic             vdd3_sel_ff
);
  // resolution for a decimation code
  function automatic logic [3:0] enob_of(input logic [1:0] code);
    case (code)
      2'b00:   enob_of = acs_pkg::ENOB_64;
      2'b01:   enob_of = acs_pkg::ENOB_128;
      2'b10:   enob_of = acs_pkg::ENOB_256;
      default: enob_of = acs_pkg::ENOB_512;
    endcase
  endfunction

  // conversion length in clocks: rate times clocks per decimation step
  function automatic logic [20:0] cycles_of(input logic [1:0] code);
    logic [12:0] rate;
    rate      = {3'b000, acs_pkg::DECIM_BASE} << code;
    // widen both factors first so a large clocks-per-step value cannot wrap the product
    cycles_of = 21'(rate) * 21'(CYC_PER_DECIM);
  endfunction

  logic [7:0]  ctrl_ff;
  logic [7:0]  test_ff;
  logic        wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [20:0] cnt_ff;
  acs_pkg::acs_state_t state_ff;

  // address phase decode
  wire logic        acc       = hsel & hready & htrans[1];
  wire logic        rd_take   = acc & ~hwrite;
  wire logic        wr_take   = acc & hwrite;
  wire logic        wr_ctrl   = wr_pend_ff & (wr_addr_ff == acs_pkg::ADDR_CTRL);
  wire logic        wr_test   = wr_pend_ff & (wr_addr_ff == acs_pkg::ADDR_TEST);
  wire logic [7:0]  nxt_ctrl  = wr_ctrl ? hwdata[7:0] : ctrl_ff;
  // reserved test bits are never stored, so they always read back zero
  wire logic [7:0]  nxt_test  = wr_test ? {7'h00, hwdata[acs_pkg::ROUTE_BIT]} : test_ff;
  wire logic [7:0]  stat_word = {6'h00, conv_done_ff, conv_busy_ff};
  // reads see the value being written in the same edge, avoiding a stale read after write
  wire logic [31:0] rd_mux    = (haddr == acs_pkg::ADDR_CTRL) ? {24'h000000, nxt_ctrl}
                              : (haddr == acs_pkg::ADDR_TEST) ? {24'h000000, nxt_test}
                              : (haddr == acs_pkg::ADDR_STAT) ? {24'h000000, stat_word}
                              : 32'h00000000;
  wire logic [1:0]  nxt_div   = nxt_ctrl[acs_pkg::DIV_LSB +: 2];
  wire logic        last_cyc  = (state_ff == acs_pkg::ACS_BUSY) & (cnt_ff == 21'h000001);

  // bus slave: always ready, always okay, unmapped reads return zero
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 32'h00000000;
      hrdata_ff    <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff   <= wr_take;
      wr_addr_ff   <= wr_take ? haddr : wr_addr_ff;
      hrdata_ff    <= rd_take ? rd_mux : 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  // register file; settings reach the core straight from these flops
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_ff <= acs_pkg::CTRL_RST;
      test_ff <= acs_pkg::TEST_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      test_ff <= nxt_test;
    end
  end

  assign single_reference_select_ff  = ctrl_ff[acs_pkg::REF_LSB +: 2];
  assign single_decimation_select_ff = ctrl_ff[acs_pkg::DIV_LSB +: 2];
  assign single_channel_select_ff    = ctrl_ff[acs_pkg::CH_LSB +: 4];
  assign temp_sensor_route_ff        = test_ff[acs_pkg::ROUTE_BIT];

  // sequencer: a control write (re)loads the timer, so a pending conversion restarts
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff       <= acs_pkg::ACS_IDLE;
      cnt_ff         <= 21'h000000;
      conv_start_ff  <= 1'b0;
      conv_busy_ff   <= 1'b0;
      conv_done_ff   <= 1'b0;
      result_bits_ff <= acs_pkg::ENOB_64;
    end else begin
      conv_start_ff <= wr_ctrl;
      if (wr_ctrl) begin
        state_ff       <= acs_pkg::ACS_BUSY;
        cnt_ff         <= cycles_of(nxt_div);
        conv_busy_ff   <= 1'b1;
        conv_done_ff   <= 1'b0;
        result_bits_ff <= enob_of(nxt_div);
      end else begin
        unique case (state_ff)
          acs_pkg::ACS_IDLE: begin
            conv_done_ff <= 1'b0;
          end
          acs_pkg::ACS_BUSY: begin
            cnt_ff <= 21'(cnt_ff - 21'h000001);
            if (last_cyc) begin
              state_ff     <= acs_pkg::ACS_IDLE;
              conv_busy_ff <= 1'b0;
              conv_done_ff <= 1'b1;
            end
          end
          default: begin
            state_ff     <= acs_pkg::ACS_IDLE;
            conv_busy_ff <= 1'b0;
            conv_done_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // channel and sensor routing selects
  acs_chan_decode u_dec (
    .clock                 (clock),
    .srst                  (srst),
    .single_channel_select (ctrl_ff[acs_pkg::CH_LSB +: 4]),
    .temp_sensor_route     (test_ff[acs_pkg::ROUTE_BIT]),
    .pos_sel_ff            (pos_sel_ff),
    .neg_sel_ff            (neg_sel_ff),
    .gnd_sel_ff            (gnd_sel_ff),
    .temp_sel_ff           (temp_sel_ff),
    .vdd3_sel_ff           (vdd3_sel_ff)
  );

  // a control write yields one start pulse two edges after its address phase
  start_once_a: assert property (@(posedge clock) disable iff (srst)
    wr_take && haddr == acs_pkg::ADDR_CTRL |-> ##2 conv_start_ff ##1 !conv_start_ff || $past(wr_ctrl))
    else $error("control write did not give one start pulse");
  // no start without a control write
  start_cause_a: assert property (@(posedge clock) disable iff (srst)
    $rose(conv_start_ff) |-> $past(wr_ctrl))
    else $error("start pulse without a control write");
  // reference field follows the written data
  ref_follow_a: assert property (@(posedge clock) disable iff (srst)
    wr_ctrl |=> single_reference_select_ff == $past(hwdata[7:6]))
    else $error("reference select did not follow write");
  // decimation field follows the written data
  div_follow_a: assert property (@(posedge clock) disable iff (srst)
    wr_ctrl |=> single_decimation_select_ff == $past(hwdata[5:4]))
    else $error("decimation select did not follow write");
  // resolution matches decimation code during a conversion
  enob_match_a: assert property (@(posedge clock) disable iff (srst)
    conv_busy_ff |-> result_bits_ff == enob_of(single_decimation_select_ff))
    else $error("resolution does not match decimation");
  // helper: busy cycles since the last start; a counter keeps long conversions cheap to check
  logic [20:0] busy_len_ff;
  wire logic [20:0] nxt_busy_len = wr_ctrl ? 21'h000000
                                 : conv_busy_ff ? 21'(busy_len_ff + 21'h000001)
                                 : busy_len_ff;

  // counter restarts with every control write, matching the reload of the timer
  always_ff @(posedge clock) begin
    if (srst) begin
      busy_len_ff <= 21'h000000;
    end else begin
      busy_len_ff <= nxt_busy_len;
    end
  end

  // a finished conversion lasted exactly its decimation rate times clocks per step
  conv_time_a: assert property (@(posedge clock) disable iff (srst)
    conv_done_ff |-> busy_len_ff == cycles_of(single_decimation_select_ff))
    else $error("conversion length does not match decimation");
  // reserved test bits read zero
  test_rsvd_a: assert property (@(posedge clock) disable iff (srst)
    test_ff[7:1] == 7'h00)
    else $error("reserved test bits not zero");
  // routing bit tracks software
  route_follow_a: assert property (@(posedge clock) disable iff (srst)
    wr_test |=> temp_sensor_route_ff == $past(hwdata[0])
    ##1 temp_sel_ff == ($past(temp_sensor_route_ff) || $past(single_channel_select_ff) == acs_pkg::CH_TEMP))
    else $error("temperature routing did not follow write");
  // a rewrite during a conversion reloads it rather than finishing the old one
  restart_a: assert property (@(posedge clock) disable iff (srst)
    wr_ctrl && conv_busy_ff |=> conv_busy_ff && !conv_done_ff)
    else $error("restart did not reload the conversion");
  // bus always answers ready and okay
  bus_okay_a: assert property (@(posedge clock) disable iff (srst)
    hreadyout_ff && !hresp_ff)
    else $error("slave stalled or answered error");
endmodule
`default_nettype wire

// [tb_adc_single_conversion_ctrl.sv]
// Purpose: self-checking bench for the single extra conversion control block
// Assumes: zero wait state slave, CYC_PER_DECIM of one, bus driven on rising edges
// Notes:   busy length is counted from the first busy cycle, done checked right after
`timescale 1ns/100ps
`default_nettype none
module tb_adc_single_conversion_ctrl;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire  logic  hready_w;
  wire  logic [31:0] hrdata_w;
  wire  logic  hresp_w;
  wire  logic [1:0] ref_w, div_w;
  wire  logic [3:0] ch_w, res_w;
  wire  logic  route_w, start_w, busy_w, done_w, gnd_w, temp_w, vdd3_w;
  wire  logic [7:0] pos_w, neg_w;
  int          err_total = 0;
  int          n_checks = 0;
  int          n_start = 0;
  int          n_wr = 0;
  int          n_done = 0;
  int          cnt;
  logic [7:0]  ep, en;
  logic [3:0]  res_tab [4] = '{4'h7, 4'h9, 4'ha, 4'hc};

  acs_ctrl #(.CYC_PER_DECIM(8'h01)) acs_ctrl_inst (
    .clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready_w), .hrdata_ff(hrdata_w), .hreadyout_ff(hready_w),
    .hresp_ff(hresp_w), .single_reference_select_ff(ref_w), .single_decimation_select_ff(div_w),
    .single_channel_select_ff(ch_w), .result_bits_ff(res_w), .temp_sensor_route_ff(route_w),
    .conv_start_ff(start_w), .conv_busy_ff(busy_w), .conv_done_ff(done_w), .pos_sel_ff(pos_w),
    .neg_sel_ff(neg_w), .gnd_sel_ff(gnd_w), .temp_sel_ff(temp_w), .vdd3_sel_ff(vdd3_w));

  // 20 MHz clock
  always #25 clock = ~clock;

  // pulse counters, so a lost or doubled start shows up in the totals; the done count is only checked across the restart test
  always @(posedge clock) begin
    if (start_w === 1'b1) n_start++;
    if (done_w === 1'b1) n_done++;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single transfer: address phase held until hready, then one data phase
  task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clock);
    while (hready_w !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready_w !== 1'b1) @(posedge clock);
    q = hrdata_w;
    chk("hresp", 32'h0, {31'h0, hresp_w});
    if (wr && a == acs_pkg::ADDR_CTRL) n_wr++;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(nm, e, q);
  endtask

  // waits for busy, counts its cycles, then expects one done pulse
  task automatic conv(input int exp_cyc);
    #1;
    cnt = 0;
    while (busy_w !== 1'b1 && cnt < 4) begin @(posedge clock); #1; cnt++; end
    cnt = 0;
    while (busy_w === 1'b1 && cnt < 2000) begin @(posedge clock); #1; cnt++; end
    chk("busy_cycles", exp_cyc, cnt);
    chk("done_pulse", 32'h1, {31'h0, done_w});
  endtask

  task automatic final_report;
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog: the tests need a few thousand cycles at most
  initial begin
    #(20000 * 50);
    err_total++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("pos_sel_rst", 32'h01, {24'h0, pos_w});
    rd("ctrl_rst", acs_pkg::ADDR_CTRL, 32'h0);
    rd("test_rst", acs_pkg::ADDR_TEST, 32'h0);
    rd("unmapped", 32'h0000_0100, 32'h0);
    // reserved test bits read zero, bit 0 routes the sensor
    // software keeps the reserved bits zero, so only the route bit is set
    wr(acs_pkg::ADDR_TEST, 32'h0000_0001);
    rd("test_rd", acs_pkg::ADDR_TEST, 32'h1);
    #1;
    chk("route_on", 32'h1, {31'h0, route_w});
    chk("temp_sel_route", 32'h1, {31'h0, temp_w});
    wr(acs_pkg::ADDR_TEST, 32'h0);
    #1;
    chk("route_off", 32'h0, {31'h0, route_w});
    // each decimation code sets resolution and busy length
    for (int d = 0; d < 4; d++) begin
      wr(acs_pkg::ADDR_CTRL, {24'h0, d[1:0], d[1:0], 4'h3});
      conv(64 << d);
      chk("result_bits", {28'h0, res_tab[d]}, {28'h0, res_w});
      chk("ref_sel", d, {30'h0, ref_w});
      chk("div_sel", d, {30'h0, div_w});
    end
    // a write while busy restarts with the new rate and drops the old done
    cnt = n_done;
    wr(acs_pkg::ADDR_CTRL, 32'h0000_0030);
    rd("status_busy", acs_pkg::ADDR_STAT, 32'h1);
    wr(acs_pkg::ADDR_CTRL, 32'h0000_0001);
    ep = 8'(n_done);
    conv(64);
    @(posedge clock);
    #1;
    chk("done_count", {24'h0, ep} + 32'h1, n_done);
    // every channel code decodes to its mux legs
    for (int c = 0; c < 16; c++) begin
      wr(acs_pkg::ADDR_CTRL, {24'h0, c[1:0], 2'h0, c[3:0]});
      repeat (3) @(posedge clock);
      #1;
      ep = 8'h0;
      en = 8'h0;
      if (c < 8) ep = 8'h01 << c;
      else if (c < 12) begin ep = 8'h01 << (2 * (c - 8)); en = 8'h02 << (2 * (c - 8)); end
      chk("ch_sel", c, {28'h0, ch_w});
      chk("legs", {13'h0, ep, en, c == 12, c == 14, c == 15}, {13'h0, pos_w, neg_w, gnd_w, temp_w, vdd3_w});
      rd("ctrl_rd", acs_pkg::ADDR_CTRL, {24'h0, c[1:0], 2'h0, c[3:0]});
    end
    repeat (600) @(posedge clock);
    chk("start_count", n_wr, n_start);
    final_report();
  end
endmodule
`default_nettype wire
